// ==== rtl/spce_pkg.sv ====
// Constants, types and helpers of the serial port command engine.
// Assumes a 40 MHz system clock and an AXI4-Lite register master.
package spce_pkg;
    localparam int AW = 12;
    localparam logic [AW-1:0] OFF_CTRL = 12'h000;
    localparam logic [AW-1:0] OFF_CMD = 12'h004;
    localparam logic [AW-1:0] OFF_TMO = 12'h008;
    localparam logic [AW-1:0] OFF_CNT = 12'h00C;
    localparam logic [AW-1:0] OFF_STAT = 12'h010;
    localparam logic [AW-1:0] OFF_AVAIL = 12'h014;
    localparam logic [AW-1:0] OFF_RES = 12'h018;
    localparam logic [AW-1:0] OFF_GOT = 12'h01C;
    localparam logic [2:0] RGN_REG = 3'h0;
    localparam logic [2:0] RGN_TX = 3'h1;
    localparam logic [2:0] RGN_RX = 3'h2;
    localparam int MEM_WORDS = 125;
    localparam logic [15:0] MAX_BYTES = 16'h00FA;
    localparam logic [15:0] CMD_INIT = 16'h10CC;
    localparam logic [15:0] CMD_PCTL = 16'h10D0;
    localparam logic [15:0] CMD_CANCEL = 16'h112F;
    localparam logic [15:0] CMD_DIAL = 16'h1130;
    localparam logic [15:0] CMD_WRITE = 16'h1131;
    localparam logic [15:0] CMD_READ = 16'h1132;
    localparam logic [15:0] CAN_ALL = 16'h0001;
    localparam logic [15:0] CAN_RD = 16'h0002;
    localparam logic [15:0] CAN_WR = 16'h0003;
    localparam int PCW_RTS = 15;
    localparam int CTL_P2P = 0;
    localparam int CTL_SIO = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int ST_RI = 15;
    localparam int ST_RS = 14;
    localparam int ST_READ_TIMEOUT_FLAG = 13;
    localparam int ST_WI = 12;
    localparam int ST_WS = 11;
    localparam int ST_WRITE_TIMEOUT_FLAG = 10;
    localparam int ST_CA = 9;
    localparam int ST_OVERFLOW_FLAG = 8;
    localparam int ST_CT = 5;
    localparam logic [1:0] RES_PEND = 2'h1;
    localparam logic [1:0] RES_OK = 2'h2;
    localparam logic [1:0] RES_FAIL = 2'h3;
    localparam int RES_RD = 0;
    localparam int RES_WR = 2;
    localparam int RES_IMM = 4;
    localparam logic [7:0] ESC_CHAR = 8'h2B;
    localparam logic [1:0] ESC_LAST = 2'h2;
    localparam logic [15:0] TX_EXTRA_S = 16'h0004;
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * TICK_S;
    localparam logic [8:0] RXB_FULL = 9'h100;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        W_IDLE = 4'b0001,
        W_ESC  = 4'b0010,
        W_DATA = 4'b0100,
        W_RESP = 4'b1000
    } spce_wst_t;

    typedef enum logic [2:0] {
        R_IDLE = 3'b001,
        R_WAIT = 3'b010,
        R_COPY = 3'b100
    } spce_rst_t;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Character n of a packed word, low byte first
    function automatic logic [7:0] pick(input logic [15:0] w,
                                        input logic hi);
        pick = hi ? w[15:8] : w[7:0];
    endfunction
endpackage

// ==== rtl/spce_top.sv ====
// Serial port command engine: AXI4-Lite registers, byte-wide serial link.
// Assumes a UART outside that takes TX bytes and delivers RX bytes.
`timescale 1ns/100ps
module spce_top #(
    parameter int SEC_CYC = spce_pkg::SEC_CYCLES
) (
    input  wire logic                    MCLK,
    input  wire logic                    RST_B,
    input  wire logic [spce_pkg::AW-1:0] AWADDR,
    input  wire logic                    AWVALID,
    output logic                         AWREADY,
    input  wire logic [31:0]             WDATA,
    input  wire logic [3:0]              WSTRB,
    input  wire logic                    WVALID,
    output logic                         WREADY,
    output logic [1:0]                   BRESP,
    output logic                         BVALID,
    input  wire logic                    BREADY,
    input  wire logic [spce_pkg::AW-1:0] ARADDR,
    input  wire logic                    ARVALID,
    output logic                         ARREADY,
    output logic [31:0]                  RDATA,
    output logic [1:0]                   RRESP,
    output logic                         RVALID,
    input  wire logic                    RREADY,
    output logic [7:0]                   TX_DATA,
    output logic                         TX_VALID,
    input  wire logic                    TX_READY,
    input  wire logic [7:0]              RX_DATA,
    input  wire logic                    RX_VALID,
    output logic                         RTS_OUT,
    output logic                         TX_DRV_EN
);
    import spce_pkg::*;

    logic [15:0] tx_mem [MEM_WORDS];
    logic [15:0] rx_mem [MEM_WORDS];
    logic [7:0]  rxb [256];
    logic [1:0]  ctrl_reg;
    logic        rts_reg;
    logic [15:0] cmd_reg, tmo_reg, cnt_reg;
    logic        ri_reg, rs_reg, wi_reg, ws_reg;
    logic        read_timeout_flag_reg, write_timeout_flag_reg;
    logic        overflow_flag_reg;
    logic [5:0]  res_reg;
    logic [7:0]  got_reg;
    logic        bvalid_reg, rvalid_reg;
    logic [1:0]  bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_next;
    spce_wst_t   w_st;
    spce_rst_t   r_st;
    logic [7:0]  w_idx, w_len, r_idx, r_len;
    logic [15:0] w_tmo, r_tmo;
    logic        w_zero, r_zero, w_dial;
    logic [1:0]  esc_cnt;
    logic [7:0]  tx_data_reg;
    logic        tx_valid_reg, drv_reg, rts_out_reg;
    logic [7:0]  rxb_wp, rxb_rp;
    logic [8:0]  rxb_cnt;
    logic [31:0] sec_cnt;
    logic        sec_tick;

    logic        wr_go, rd_go, wr_ok, cmd_we, stat_rd, tx_fire;
    logic        wr_busy, rd_busy, len_ok;
    logic        start_wr, start_dial, start_rd, rd_zero;
    logic        abort_wr, abort_rd, cmd_acc;
    logic        w_fin_ok, w_fin_to, r_fin_ok, r_fin_to;
    logic        rx_push, r_commit;
    logic [15:0] ncmd;
    logic [6:0]  aw_word, ar_word;
    logic [7:0]  w_nidx, r_pos;

    // Both write channels are taken together; either may arrive first
    assign wr_go   = AWVALID & WVALID & ~bvalid_reg;
    assign AWREADY = wr_go;
    assign WREADY  = wr_go;
    assign rd_go   = ARVALID & ~rvalid_reg;
    assign ARREADY = ~rvalid_reg;
    assign BVALID  = bvalid_reg;
    assign BRESP   = bresp_reg;
    assign RVALID  = rvalid_reg;
    assign RRESP   = rresp_reg;
    assign RDATA   = rdata_reg;
    assign TX_DATA  = tx_data_reg;
    assign TX_VALID = tx_valid_reg;
    assign RTS_OUT   = rts_out_reg;
    assign TX_DRV_EN = drv_reg;
    assign aw_word = AWADDR[8:2];
    assign ar_word = ARADDR[8:2];

    // Which writes land somewhere; unmapped ones answer SLVERR
    always_comb begin
        wr_ok = 1'b0;
        if (AWADDR[11:9] == RGN_REG) begin
            wr_ok = AWADDR[8:5] == 4'h0;
        end else if (AWADDR[11:9] == RGN_TX) begin
            wr_ok = aw_word < 7'(MEM_WORDS);
        end
    end

    // Command decode; arguments come from registers written earlier
    assign ncmd    = WDATA[15:0];
    assign cmd_we  = wr_go & (AWADDR == OFF_CMD) & (WSTRB[1:0] == 2'h3);
    assign wr_busy = w_st != W_IDLE;
    assign rd_busy = r_st != R_IDLE;
    assign len_ok  = (cnt_reg != 16'h0000) & (cnt_reg <= MAX_BYTES);
    assign start_wr = cmd_we & (ncmd == CMD_WRITE) & ~wr_busy & len_ok;
    assign start_dial = cmd_we & (ncmd == CMD_DIAL) & ~wr_busy & len_ok
                      & ctrl_reg[CTL_SIO];
    assign start_rd = cmd_we & (ncmd == CMD_READ) & ~rd_busy & len_ok;
    assign rd_zero  = cmd_we & (ncmd == CMD_READ) & ~rd_busy
                    & (cnt_reg == 16'h0000);
    assign abort_rd = cmd_we & (ncmd == CMD_CANCEL)
                    & (cnt_reg == CAN_ALL | cnt_reg == CAN_RD);
    assign abort_wr = cmd_we & ((ncmd == CMD_INIT) | (ncmd == CMD_CANCEL)
                    & (cnt_reg == CAN_ALL | cnt_reg == CAN_WR));
    assign cmd_acc  = start_wr | start_dial | start_rd | rd_zero
                    | (ncmd == CMD_INIT) | (ncmd == CMD_PCTL)
                    | (ncmd == CMD_CANCEL & cnt_reg >= CAN_ALL
                       & cnt_reg <= CAN_WR);

    // Free one-second tick shared by every timeout
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            sec_cnt <= 32'h0;
        end else if (sec_cnt == 32'(SEC_CYC - 1)) begin
            sec_cnt <= 32'h0;
        end else begin
            sec_cnt <= sec_cnt + 32'h1;
        end
    end
    assign sec_tick = sec_cnt == 32'(SEC_CYC - 1);

    // Software-written control and argument registers
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            ctrl_reg <= CTRL_RST;
            rts_reg  <= 1'b0;
            cmd_reg  <= 16'h0000;
            tmo_reg  <= 16'h0000;
            cnt_reg  <= 16'h0000;
        end else if (wr_go) begin
            if (AWADDR == OFF_CTRL && WSTRB[0]) begin
                ctrl_reg <= WDATA[1:0]; // Both mode bits in the low lane
            end
            if (AWADDR == OFF_TMO) begin
                tmo_reg <= merge16(tmo_reg, WDATA, WSTRB);
            end
            if (AWADDR == OFF_CNT) begin
                cnt_reg <= merge16(cnt_reg, WDATA, WSTRB);
            end
            if (cmd_we) begin
                cmd_reg <= ncmd;
            end
            if (cmd_we && ncmd == CMD_PCTL) begin
                rts_reg <= cnt_reg[PCW_RTS];
            end
        end
    end

    // Transmit source words; software keeps them until done
    always_ff @(posedge MCLK) begin
        if (wr_go && AWADDR[11:9] == RGN_TX && aw_word < 7'(MEM_WORDS)) begin
            tx_mem[aw_word] <= merge16(tx_mem[aw_word], WDATA, WSTRB);
        end
    end

    // Line driver and RTS; registered so the pins never glitch
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            drv_reg     <= 1'b0;
            rts_out_reg <= 1'b0;
        end else begin
            drv_reg     <= ctrl_reg[CTL_P2P] | (w_st == W_ESC)
                         | (w_st == W_DATA);
            rts_out_reg <= rts_reg & (ctrl_reg[CTL_P2P] | (w_st == W_ESC)
                         | (w_st == W_DATA));
        end
    end

    // Writer completion; a finish beats a timeout in the same cycle
    assign tx_fire  = tx_valid_reg & TX_READY;
    assign w_nidx   = w_idx + 8'h1;
    assign w_fin_ok = (w_st == W_DATA & tx_fire & w_nidx == w_len
                       & ~(w_dial & ~w_zero))
                    | (w_st == W_RESP & RX_VALID);
    assign w_fin_to = wr_busy & ~w_fin_ok & sec_tick & w_tmo == 16'h1
                    & ~abort_wr;

    // Write-bytes and autodial sequencer
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            w_st         <= W_IDLE;
            w_idx        <= 8'h00;
            w_len        <= 8'h00;
            w_tmo        <= 16'h0000;
            w_zero       <= 1'b0;
            w_dial       <= 1'b0;
            esc_cnt      <= 2'h0;
            tx_data_reg  <= 8'h00;
            tx_valid_reg <= 1'b0;
        end else if (abort_wr) begin
            w_st         <= W_IDLE;
            tx_valid_reg <= 1'b0;
        end else if (w_fin_ok || w_fin_to) begin
            w_st         <= W_IDLE;
            tx_valid_reg <= 1'b0;
        end else begin
            if (wr_busy && sec_tick) begin
                w_tmo <= w_tmo - 16'h1;
            end
            unique case (w_st)
                W_IDLE: begin
                    if (start_wr || start_dial) begin
                        w_len        <= cnt_reg[7:0];
                        w_idx        <= 8'h00;
                        esc_cnt      <= 2'h0;
                        w_dial       <= start_dial;
                        w_zero       <= tmo_reg == 16'h0000;
                        w_tmo        <= (tmo_reg == 16'h0000) ? TX_EXTRA_S
                                                              : tmo_reg;
                        tx_valid_reg <= 1'b1;
                        tx_data_reg  <= start_dial ? ESC_CHAR
                                      : pick(tx_mem[0], 1'b0);
                        w_st         <= start_dial ? W_ESC : W_DATA;
                    end
                end
                W_ESC: begin
                    if (tx_fire) begin
                        esc_cnt <= esc_cnt + 2'h1;
                        if (esc_cnt == ESC_LAST) begin
                            tx_data_reg <= pick(tx_mem[0], 1'b0);
                            w_st        <= W_DATA;
                        end
                    end
                end
                W_DATA: begin
                    if (tx_fire) begin
                        w_idx <= w_nidx;
                        if (w_zero) begin
                            w_tmo <= TX_EXTRA_S;
                        end
                        if (w_nidx == w_len) begin
                            tx_valid_reg <= 1'b0;
                            w_tmo        <= tmo_reg;
                            w_st         <= W_RESP;
                        end else begin
                            tx_data_reg <= pick(tx_mem[w_nidx[7:1]],
                                                w_nidx[0]);
                        end
                    end
                end
                W_RESP: begin
                end
                default: w_st <= W_IDLE;
            endcase
        end
    end

    // Reader: waits for enough bytes, copies, then commits the pop
    assign r_pos    = rxb_rp + r_idx;
    assign r_commit = (r_st == R_COPY) & (r_idx == r_len - 8'h1);
    assign r_fin_ok = r_commit & ~abort_rd;
    assign r_fin_to = (r_st == R_WAIT) & ~r_zero & sec_tick
                    & r_tmo == 16'h1 & (rxb_cnt < {1'b0, r_len})
                    & ~abort_rd;
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            r_st   <= R_IDLE;
            r_idx  <= 8'h00;
            r_len  <= 8'h00;
            r_tmo  <= 16'h0000;
            r_zero <= 1'b0;
        end else if (abort_rd || r_fin_ok || r_fin_to) begin
            r_st <= R_IDLE;
        end else begin
            unique case (r_st)
                R_IDLE: begin
                    if (start_rd) begin
                        r_len  <= cnt_reg[7:0];
                        r_tmo  <= tmo_reg;
                        r_zero <= tmo_reg == 16'h0000;
                        r_st   <= R_WAIT;
                    end
                end
                R_WAIT: begin
                    if (sec_tick) begin
                        r_tmo <= r_tmo - 16'h1;
                    end
                    if (rxb_cnt >= {1'b0, r_len}) begin
                        r_idx <= 8'h00;
                        r_st  <= R_COPY;
                    end
                end
                R_COPY: r_idx <= r_idx + 8'h1;
                default: r_st <= R_IDLE;
            endcase
        end
    end

    // Destination words; odd tail has its high byte cleared
    always_ff @(posedge MCLK) begin
        if (r_st == R_COPY) begin
            if (!r_idx[0]) begin
                rx_mem[r_idx[7:1]] <= {8'h00, rxb[r_pos]};
            end else begin
                rx_mem[r_idx[7:1]][15:8] <= rxb[r_pos];
            end
        end
    end

    // Receive buffer; a full buffer drops the new byte
    assign rx_push = RX_VALID & (rxb_cnt != RXB_FULL);
    always_ff @(posedge MCLK) begin
        if (rx_push) begin
            rxb[rxb_wp] <= RX_DATA;
        end
    end
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            rxb_wp  <= 8'h00;
            rxb_rp  <= 8'h00;
            rxb_cnt <= 9'h000;
        end else begin
            if (rx_push) begin
                rxb_wp <= rxb_wp + 8'h1;
            end
            if (r_fin_ok) begin
                rxb_rp <= rxb_rp + r_len;
            end
            rxb_cnt <= rxb_cnt + {8'h00, rx_push}
                     - (r_fin_ok ? {1'b0, r_len} : 9'h000);
        end
    end

    // Port status flags; setting wins over the read-clear
    assign stat_rd = rd_go & (ARADDR == OFF_STAT);
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            ri_reg <= 1'b0;
            rs_reg <= 1'b0;
            read_timeout_flag_reg  <= 1'b0;
            wi_reg <= 1'b0;
            ws_reg <= 1'b0;
            write_timeout_flag_reg <= 1'b0;
            overflow_flag_reg      <= 1'b0;
        end else begin
            ri_reg <= start_rd | ri_reg & ~(r_fin_ok | r_fin_to | abort_rd);
            rs_reg <= r_fin_ok | rd_zero | rs_reg & ~start_rd;
            read_timeout_flag_reg <= r_fin_to
                                   | read_timeout_flag_reg & ~start_rd;
            wi_reg <= start_wr | start_dial
                    | wi_reg & ~(w_fin_ok | w_fin_to | abort_wr);
            ws_reg <= w_fin_ok | ws_reg & ~(start_wr | start_dial);
            write_timeout_flag_reg <= w_fin_to | write_timeout_flag_reg
                                    & ~(start_wr | start_dial);
            overflow_flag_reg <= (RX_VALID & ~rx_push)
                               | overflow_flag_reg & ~stat_rd;
        end
    end

    // Completion words; aborts leave the read and write fields untouched, except a write that finishes in the abort cycle and still reports RES_OK
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            res_reg <= 6'h00;
            got_reg <= 8'h00;
        end else begin
            if (cmd_we) begin
                res_reg[RES_IMM+:2] <= cmd_acc ? RES_OK : RES_FAIL;
            end
            if (start_rd) begin
                res_reg[RES_RD+:2] <= RES_PEND;
            end else if (rd_zero || r_fin_ok) begin
                res_reg[RES_RD+:2] <= RES_OK;
            end else if (r_fin_to) begin
                res_reg[RES_RD+:2] <= RES_FAIL;
            end
            if (start_rd || rd_zero) begin
                got_reg <= 8'h00;
            end else if (r_fin_ok) begin
                got_reg <= r_len;
            end
            if (start_wr || start_dial) begin
                res_reg[RES_WR+:2] <= RES_PEND;
            end else if (w_fin_ok) begin
                res_reg[RES_WR+:2] <= RES_OK;
            end else if (w_fin_to) begin
                res_reg[RES_WR+:2] <= RES_FAIL;
            end
        end
    end

    // Read data selection
    always_comb begin
        rdata_next = 32'h0;
        rresp_next = RESP_OKAY;
        if (ARADDR[11:9] == RGN_REG) begin
            unique case (ARADDR)
                OFF_CTRL:  rdata_next = {16'h0, rts_reg, 13'h0, ctrl_reg};
                OFF_CMD:   rdata_next = {16'h0, cmd_reg};
                OFF_TMO:   rdata_next = {16'h0, tmo_reg};
                OFF_CNT:   rdata_next = {16'h0, cnt_reg};
                OFF_STAT:  rdata_next = {16'h0, ri_reg, rs_reg,
                                         read_timeout_flag_reg,
                                         wi_reg, ws_reg,
                                         write_timeout_flag_reg,
                                         rxb_cnt != 9'h0,
                                         overflow_flag_reg,
                                         2'h0, 1'b1, 5'h00};
                OFF_AVAIL: rdata_next = {23'h0, rxb_cnt};
                OFF_RES:   rdata_next = {26'h0, res_reg};
                OFF_GOT:   rdata_next = {24'h0, got_reg};
                default:   rresp_next = RESP_SLVERR;
            endcase
        end else if (ARADDR[11:9] == RGN_TX && ar_word < 7'(MEM_WORDS)) begin
            rdata_next = {16'h0, tx_mem[ar_word]};
        end else if (ARADDR[11:9] == RGN_RX && ar_word < 7'(MEM_WORDS)) begin
            rdata_next = {16'h0, rx_mem[ar_word]};
        end else begin
            rresp_next = RESP_SLVERR;
        end
    end

    // AXI answers, held until the master takes them
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0;
        end else begin
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (BREADY) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= rresp_next;
                rdata_reg  <= rdata_next;
            end else if (RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
endmodule

// ==== bench/spce_props.sv ====
// Port checker of the serial command engine.
// Bound into spce_top; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module spce_props(
    input wire logic        MCLK, RST_B, AWVALID, WVALID, BVALID, BREADY,
    input wire logic        ARVALID, ARREADY, RVALID, RREADY, TX_VALID,
    input wire logic        TX_READY, RTS_OUT, TX_DRV_EN,
    input wire logic [1:0]  BRESP,
    input wire logic [31:0] RDATA,
    input wire logic [7:0]  TX_DATA
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // Bus take and line stall, reused below
    sequence s_wtake; AWVALID && WVALID && !BVALID; endsequence
    sequence s_tstall; TX_VALID && !TX_READY ##1 TX_VALID; endsequence
    // Line RTS only through an enabled driver
    a_rts_gated: assert property (RTS_OUT |-> TX_DRV_EN)
        else $error("line RTS without driver");
    a_drv_on_tx: assert property (TX_VALID |=> TX_DRV_EN)
        else $error("driver off while sending");
    // A stalled byte must not change under the far side
    a_tx_steady: assert property (s_tstall |-> $stable(TX_DATA))
        else $error("byte changed while stalled");
    a_wr_answer: assert property (s_wtake |=> BVALID)
        else $error("write not answered");
    a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped");
    a_b_drop: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write answer repeated");
    a_rd_answer: assert property (ARVALID && !RVALID |=> RVALID)
        else $error("read not answered");
    a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer dropped");
    a_ar_ready: assert property (ARREADY == !RVALID)
        else $error("read ready wrong");
endmodule
bind spce_top spce_props u_props(.*);

// ==== bench/spce_far.sv ====
// Far-side serial device: stalls the sender, records and sends bytes.
// Assumes the byte-wide link of spce_top on one clock.
`timescale 1ns/100ps
module spce_far(
    input  wire logic MCLK, TX_VALID, input wire logic [7:0] TX_DATA,
    output logic TX_READY, RX_VALID, output logic [7:0] RX_DATA
);
    logic [7:0] got[$];
    logic [1:0] ph = 2'h0;
    initial {TX_READY, RX_VALID, RX_DATA} = 10'h000;
    // Flow control stalls one cycle in four
    always @(posedge MCLK) begin
        ph <= ph + 2'h1;
        TX_READY <= (ph != 2'h2);
        if (TX_VALID && TX_READY) got.push_back(TX_DATA);
    end
    // One pulse per byte; idle data shows the inverse, never a stale copy
    task send(input logic [7:0] c);
        @(posedge MCLK);
        RX_DATA <= c;
        RX_VALID <= 1'b1;
        @(posedge MCLK);
        RX_VALID <= 1'b0;
        RX_DATA <= ~c;
    endtask
endmodule

// ==== bench/spce_top_tb.sv ====
// Self-checking bench of the serial command engine.
// Assumes spce_top with a 20-cycle second tick and the far-side model.
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    num_errors++; $display("wrong value %s exp %0h got %0h", n, e, s); end end
module spce_top_tb;
    import spce_pkg::*;
    logic MCLK = 0, RST_B = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
    logic ARVALID = 0, RREADY = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic TX_VALID, TX_READY, RX_VALID, RTS_OUT, TX_DRV_EN;
    logic [11:0] AWADDR = 0, ARADDR = 0;
    logic [31:0] WDATA = 0, RDATA, rd;
    logic [3:0]  WSTRB = 4'hF;
    logic [1:0]  BRESP, RRESP, rr;
    logic [7:0]  TX_DATA, RX_DATA, b[3];
    int num_errors = 0, cmp_count = 0, cyc = 0, seed = 11;
    always #12.5 MCLK = ~MCLK;
    spce_top #(.SEC_CYC(20)) u_dut(.*);
    spce_far u_far(.*);
    // Expected packing: earlier character in the low byte
    function logic [31:0] pk(input logic [7:0] lo, input logic [7:0] hi);
        return {16'h0000, hi, lo};
    endfunction
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge MCLK);
        {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, d, 3'h7};
        do @(posedge MCLK); while (!AWREADY);
        {AWVALID, WVALID} <= 2'h0;
        do @(posedge MCLK); while (!BVALID);
        BREADY <= 1'b0;
    endtask
    task rdr(input logic [11:0] a);
        @(posedge MCLK);
        {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
        do @(posedge MCLK); while (!ARREADY);
        ARVALID <= 1'b0;
        do @(posedge MCLK); while (!RVALID);
        {rd, rr} = {RDATA, RRESP};
        RREADY <= 1'b0;
    endtask
    // Polls the result field; bounded so a hang still reports
    task wait_res(input int sh, input logic [1:0] e);
        repeat (300) begin rdr(OFF_RES); if (rd[sh+:2] === e) break; end
        `CHK("result", e, rd[sh+:2])
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 30000) begin num_errors++; print_verdict; end
    end
    initial begin
        repeat (8) @(posedge MCLK);
        RST_B <= 1'b1;
        rdr(OFF_STAT);
        `CHK("status", 32'h20, rd)
        rdr(12'h0FC);
        `CHK("unmapped", RESP_SLVERR, rr)
        for (int i = 0; i < 3; i++) b[i] = 8'($random(seed));
        wr(12'h200, pk(b[0], b[1]));
        wr(12'h204, pk(b[2], 8'h00));
        wr(OFF_TMO, 0);
        wr(OFF_CNT, 3);
        wr(OFF_CMD, CMD_WRITE);
        wait_res(RES_WR, RES_OK);
        `CHK("tx count", 3, u_far.got.size())
        for (int i = 0; i < 3; i++) `CHK("tx byte", b[i], u_far.got[i])
        $display("write test done");
        for (int i = 0; i < 3; i++) u_far.send(b[i]);
        wr(OFF_CNT, 0);
        wr(OFF_CMD, CMD_READ);
        rdr(OFF_AVAIL);
        `CHK("avail", 32'h3, rd)
        wr(OFF_CNT, 3);
        wr(OFF_CMD, CMD_READ);
        wait_res(RES_RD, RES_OK);
        rdr(OFF_GOT);
        `CHK("got", 32'h3, rd)
        rdr(12'h400);
        `CHK("rx word", pk(b[0], b[1]), rd)
        rdr(12'h404);
        `CHK("rx last", pk(b[2], 8'h00), rd)
        $display("read test done");
        u_far.send(8'h5A);
        wr(OFF_CNT, 2);
        wr(OFF_CMD, CMD_READ);
        wr(OFF_CNT, CAN_RD);
        wr(OFF_CMD, CMD_CANCEL);
        rdr(OFF_RES);
        `CHK("cancelled", RES_PEND, rd[1:0])
        rdr(OFF_AVAIL);
        `CHK("kept", 32'h1, rd)
        $display("cancel test done");
        wr(OFF_CTRL, 1);
        wr(OFF_CNT, 32'h8000);
        wr(OFF_CMD, CMD_PCTL);
        repeat (3) @(negedge MCLK);
        `CHK("rts p2p", 1'b1, RTS_OUT)
        wr(OFF_CTRL, 0);
        repeat (3) @(negedge MCLK);
        `CHK("rts idle", 1'b0, RTS_OUT)
        $display("rts test done");
        wr(OFF_TMO, 2);
        wr(OFF_CNT, 5);
        wr(OFF_CMD, CMD_READ);
        wait_res(RES_RD, RES_FAIL);
        rdr(OFF_STAT);
        `CHK("rd timeout", 1'b1, rd[ST_READ_TIMEOUT_FLAG])
        rdr(OFF_AVAIL);
        `CHK("kept fail", 32'h1, rd)
        repeat (256) u_far.send(8'hC3);
        rdr(OFF_STAT);
        `CHK("overflow", 1'b1, rd[ST_OVERFLOW_FLAG])
        rdr(OFF_STAT);
        `CHK("ovf clear", 1'b0, rd[ST_OVERFLOW_FLAG])
        rdr(OFF_AVAIL);
        `CHK("full", 32'h100, rd)
        $display("timeout and overflow test done");
        wr(OFF_TMO, 0);
        wr(OFF_CNT, 1);
        wr(OFF_CMD, CMD_DIAL);
        rdr(OFF_RES);
        `CHK("dial refused", RES_FAIL, rd[RES_IMM+:2])
        wr(OFF_CTRL, 2);
        wr(OFF_CMD, CMD_DIAL);
        wait_res(RES_WR, RES_OK);
        `CHK("dial count", 7, u_far.got.size())
        for (int i = 3; i < 6; i++) `CHK("esc", ESC_CHAR, u_far.got[i])
        `CHK("dial byte", b[0], u_far.got[6])
        $display("autodial test done");
        print_verdict;
    end
endmodule
